// ---- hw/bst_tap.v ----
// What this block does
// [RQ1] A standard test port with all mandatory and listed optional codes.
// [RQ2] Code 111 puts a one-stage register between TDI and TDO.
// [RQ3] Code 000 drives the boundary update stage onto the output pins.
// [RQ4] Code 001 captures pin inputs and system outputs and allows preload.
// [RQ5] Code 010 shifts the identification register out on TDO.
// [RQ6] Code 011 floats every output and two-way pin.
// [RQ7] Pull-ups need not all be disabled while outputs float.
// [RQ8] Code 100 selects bypass and drives pins from the boundary register.
// [RQ9] Under code 100 the clamped pin values do not change while scanning.
// [RQ10] Display converter and USB pins have no boundary cells.
// [RQ11] The instruction is three bits, shifted least significant bit first.
// [RQ12] Codes 101 and 110 behave like bypass.
`timescale 1ns/100ps
`include "bst_consts.vh"
module bst_tap #(
  parameter NPIN = 8,
  parameter [31:0] IDCODE_VAL = 32'h00000001 // Arbitrary value.
) (
  CLK,
  RST,
  TCK,
  TMS,
  TDI,
  TRST_N,
  TDO,
  TDO_OE,
  SYS_OUT,
  SYS_OE,
  PIN_IN,
  PIN_OUT,
  PIN_OE,
  PULLUP_EN
);
  input wire CLK;
  input wire RST;
  input wire TCK;
  input wire TMS;
  input wire TDI;
  input wire TRST_N;
  output reg TDO;
  output reg TDO_OE;
  input wire [NPIN-1:0] SYS_OUT;
  input wire [NPIN-1:0] SYS_OE;
  input wire [NPIN-1:0] PIN_IN;
  output reg [NPIN-1:0] PIN_OUT;
  output reg [NPIN-1:0] PIN_OE;
  output wire PULLUP_EN;

  // ****************************************
  // Input synchronisers and test clock edges.
  // ****************************************
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg tck_old_q;
  // Bit 0 test clock, 1 mode, 2 data in, 3 test reset (low active).
  always @(posedge CLK) begin
    if (RST) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      tck_old_q <= 1'b0;
    end else begin
      s1_q <= {TRST_N, TDI, TMS, TCK};
      s2_q <= s1_q;
      tck_old_q <= s2_q[0];
    end
  end
  wire tck_s = s2_q[0];
  wire tms_s = s2_q[1];
  wire tdi_s = s2_q[2];
  // The test reset acts only after both synchroniser stages.
  wire trst_s = ~s2_q[3];
  wire rise = tck_s & ~tck_old_q;
  wire fall = ~tck_s & tck_old_q;

  reg [NPIN-1:0] pin_s1_q;
  reg [NPIN-1:0] pin_s2_q;
  always @(posedge CLK) begin
    if (RST) begin
      pin_s1_q <= {NPIN{1'b0}};
      pin_s2_q <= {NPIN{1'b0}};
    end else begin
      pin_s1_q <= PIN_IN;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************
  // Controller state machine.
  // ****************************************
  reg [3:0] st_q;
  reg [3:0] st_d;
  // Sixteen-state controller, stepped on each test clock rise.
  always @* begin
    case (st_q)
      `BST_ST_RESET: st_d = tms_s ? `BST_ST_RESET : `BST_ST_IDLE;
      `BST_ST_IDLE: st_d = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      `BST_ST_SEL_DR: st_d = tms_s ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
      `BST_ST_CAP_DR: st_d = tms_s ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
      `BST_ST_SH_DR: st_d = tms_s ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
      `BST_ST_EX1_DR: st_d = tms_s ? `BST_ST_UPD_DR : `BST_ST_PAU_DR;
      `BST_ST_PAU_DR: st_d = tms_s ? `BST_ST_EX2_DR : `BST_ST_PAU_DR;
      `BST_ST_EX2_DR: st_d = tms_s ? `BST_ST_UPD_DR : `BST_ST_SH_DR;
      `BST_ST_UPD_DR: st_d = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      `BST_ST_SEL_IR: st_d = tms_s ? `BST_ST_RESET : `BST_ST_CAP_IR;
      `BST_ST_CAP_IR: st_d = tms_s ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
      `BST_ST_SH_IR: st_d = tms_s ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
      `BST_ST_EX1_IR: st_d = tms_s ? `BST_ST_UPD_IR : `BST_ST_PAU_IR;
      `BST_ST_PAU_IR: st_d = tms_s ? `BST_ST_EX2_IR : `BST_ST_PAU_IR;
      `BST_ST_EX2_IR: st_d = tms_s ? `BST_ST_UPD_IR : `BST_ST_SH_IR;
      `BST_ST_UPD_IR: st_d = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      default: st_d = `BST_ST_RESET;
    endcase
  end

  // ****************************************
  // Instruction and data registers.
  // ****************************************
  reg [2:0] ir_sh_q;
  reg [2:0] ir_q;
  reg byp_q;
  reg [31:0] id_q;
  reg [2*NPIN-1:0] bsr_q;
  reg [2*NPIN-1:0] upd_q;

  // Instruction decode.
  wire sel_bsr = (ir_q == `BST_OP_EXTEST) | (ir_q == `BST_OP_SAMPLE);
  wire sel_id = (ir_q == `BST_OP_IDCODE);
  // Every other code, reserved ones included, selects the bypass stage.
  wire sel_byp = ~sel_bsr & ~sel_id; // [RQ2] [RQ8] [RQ12]
  wire drive_bsr = (ir_q == `BST_OP_EXTEST) | (ir_q == `BST_OP_CLAMP);
  wire float_all_outputs = (ir_q == `BST_OP_FLOAT);
  // A data cell takes the core value where driven, else the pin level.
  wire [NPIN-1:0] cap_data = (SYS_OE & SYS_OUT) | (~SYS_OE & pin_s2_q);

  always @(posedge CLK) begin
    if (RST | trst_s) begin
      st_q <= `BST_ST_RESET;
      ir_sh_q <= 3'h0;
      ir_q <= `BST_OP_IDCODE;
      byp_q <= 1'b0;
      id_q <= 32'h00000000;
      bsr_q <= {2*NPIN{1'b0}};
      upd_q <= {2*NPIN{1'b0}};
    end else if (rise) begin
      st_q <= st_d;
      case (st_q)
        `BST_ST_RESET: ir_q <= `BST_OP_IDCODE;
        `BST_ST_CAP_IR: ir_sh_q <= `BST_IR_CAPTURE;
        `BST_ST_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[2:1]}; // [RQ11]
        `BST_ST_UPD_IR: ir_q <= ir_sh_q; // [RQ1]
        `BST_ST_CAP_DR: begin
          byp_q <= 1'b0;
          id_q <= IDCODE_VAL;
          if (sel_bsr) begin
            bsr_q <= {SYS_OE, cap_data}; // [RQ4]
          end
        end
        `BST_ST_SH_DR: begin
          byp_q <= tdi_s; // [RQ2]
          id_q <= {tdi_s, id_q[31:1]}; // [RQ5]
          if (sel_bsr) begin
            bsr_q <= {tdi_s, bsr_q[2*NPIN-1:1]};
          end
        end
        `BST_ST_UPD_DR: begin
          // The update stage moves only under a boundary instruction.
          if (sel_bsr) begin
            upd_q <= bsr_q; // [RQ4] [RQ9]
          end
        end
        default: ir_q <= ir_q;
      endcase
    end
  end

  // ****************************************
  // Serial output, changing on the falling test clock.
  // ****************************************
  // The enable is loaded at each falling test clock from whether a shift state is current.
  wire sh_st = (st_q == `BST_ST_SH_DR) | (st_q == `BST_ST_SH_IR);
  always @(posedge CLK) begin
    if (RST | trst_s) begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (fall) begin
      TDO_OE <= sh_st;
      if (st_q == `BST_ST_SH_IR) begin
        TDO <= ir_sh_q[0];
      end else if (sel_id) begin
        TDO <= id_q[0]; // [RQ5]
      end else if (sel_bsr) begin
        TDO <= bsr_q[0];
      end else begin
        TDO <= byp_q; // [RQ2]
      end
    end
  end

  // ****************************************
  // Pin control; display and USB pins carry no cells.
  // ****************************************
  always @(posedge CLK) begin
    if (RST) begin
      PIN_OUT <= {NPIN{1'b0}};
      PIN_OE <= {NPIN{1'b0}};
    end else if (float_all_outputs) begin
      // A floated pin keeps the core value ready for when float ends.
      PIN_OUT <= SYS_OUT;
      PIN_OE <= {NPIN{1'b0}}; // [RQ6]
    end else if (drive_bsr) begin
      PIN_OUT <= upd_q[NPIN-1:0]; // [RQ3] [RQ8] [RQ9]
      PIN_OE <= upd_q[2*NPIN-1:NPIN];
    end else begin
      PIN_OUT <= SYS_OUT;
      PIN_OE <= SYS_OE;
    end
  end

  // Pull-ups stay on whatever the instruction.
  assign PULLUP_EN = 1'b1; // [RQ7] [RQ10]
endmodule

// ---- hw/bst_consts.vh ----
`ifndef BST_CONSTS_VH
`define BST_CONSTS_VH
`define BST_IR_W 3
`define BST_OP_EXTEST 3'h0
`define BST_OP_SAMPLE 3'h1
`define BST_OP_IDCODE 3'h2
`define BST_OP_FLOAT 3'h3
`define BST_OP_CLAMP 3'h4
`define BST_OP_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1
`define BST_ST_RESET 4'h0
`define BST_ST_IDLE 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SH_DR 4'h4
`define BST_ST_EX1_DR 4'h5
`define BST_ST_PAU_DR 4'h6
`define BST_ST_EX2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_IR 4'h9
`define BST_ST_CAP_IR 4'ha
`define BST_ST_SH_IR 4'hb
`define BST_ST_EX1_IR 4'hc
`define BST_ST_PAU_IR 4'hd
`define BST_ST_EX2_IR 4'he
`define BST_ST_UPD_IR 4'hf
`endif

// ---- verif/bst_tap_chk_props.sv ----
`timescale 1ns/100ps
module bst_tap_chk #(parameter NPIN = 8) (
  input wire CLK, RST, TCK, TMS, TDI, TRST_N, TDO, TDO_OE, PULLUP_EN,
  input wire [NPIN-1:0] SYS_OUT, SYS_OE, PIN_IN, PIN_OUT, PIN_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || !TRST_N);
  pullup_on_a: assert property (PULLUP_EN)
    else $error("pull-ups disabled");
  reset_tdo_a: assert property (disable iff (1'b0)
    RST |=> !TDO && !TDO_OE) else $error("serial out not cleared");
  reset_pins_a: assert property (disable iff (1'b0)
    RST |=> PIN_OUT == 0 && PIN_OE == 0) else $error("pins not cleared");
  tdo_change_a: assert property (TCK || $past(TCK, 2) |->
    $stable(TDO)) else $error("serial out moved in high phase");
  oe_rise_a: assert property ($rose(TDO_OE) |-> !TCK)
    else $error("enable rose in high phase");
  shift_hold_a: assert property (TCK [*3] |->
    $stable(TDO_OE) && $stable(TDO)) else $error("serial out unstable");
  oe_gap_a: assert property ($fell(TDO_OE) |=> !TDO_OE [*8])
    else $error("shift restarted too soon");
  pin_hold_a: assert property (TDO_OE && $past(TDO_OE) &&
    $past(SYS_OUT) == $past(SYS_OUT, 2) &&
    $past(SYS_OE) == $past(SYS_OE, 2) |->
    $stable(PIN_OUT) && $stable(PIN_OE)) else $error("pins moved in scan");
endmodule
bind bst_tap bst_tap_chk #(.NPIN(NPIN)) u_bst_tap_chk(.CLK(CLK),
  .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO),
  .TDO_OE(TDO_OE), .PULLUP_EN(PULLUP_EN), .SYS_OUT(SYS_OUT),
  .SYS_OE(SYS_OE), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

// ---- verif/bst_jtm.sv ----
`timescale 1ns/100ps
module bst_jtm (
  input wire CLK,
  input wire TDO,
  output reg TCK = 1'b0,
  output reg TMS = 1'b1,
  output reg TDI = 1'b0
);
  // Long and short high phases alternate so the test clock averages 125 ns.
  reg lng = 1'b0;
  // One test clock period; called at a rising CLK edge and returns at one.
  task b(input m, input d, output o);
    TMS <= m;
    TDI <= d;
    TCK <= 1'b0;
    repeat (5) @(posedge CLK);
    @(negedge CLK) o = TDO;
    @(posedge CLK) TCK <= 1'b1;
    repeat (6 + lng) @(posedge CLK);
    lng = ~lng;
  endtask
  task sh(input ir, input int n, input [31:0] v, output [31:0] r);
    reg x;
    r = 32'h0;
    b(1'b1, 1'b0, x);
    if (ir) b(1'b1, 1'b0, x);
    b(1'b0, 1'b0, x);
    b(1'b0, 1'b0, x);
    for (int i = 0; i < n; i++) b(i == n - 1, v[i], r[i]);
    b(1'b1, 1'b0, x);
    b(1'b0, 1'b0, x);
  endtask
endmodule

// ---- verif/bst_tap_tb_top.sv ----
`timescale 1ns/100ps
module bst_tap_tb_top;
  localparam [31:0] ID = 32'h5a5a0001; // Arbitrary value.
  reg CLK = 1'b0, RST = 1'b1, TRST_N = 1'b1;
  reg [7:0] SYS_OUT = 8'h00, SYS_OE = 8'h00, PIN_IN = 8'h00;
  wire TCK, TMS, TDI, TDO, TDO_OE, PULLUP_EN;
  wire [7:0] PIN_OUT, PIN_OE;
  int n_errors = 0, comparisons = 0, cyc = 0;
  reg [31:0] r, pv, lf = 32'hfd33deae;
  always #5 CLK = ~CLK;
  bst_tap #(.NPIN(8), .IDCODE_VAL(ID)) u_bst_tap(.CLK(CLK), .RST(RST),
    .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO),
    .TDO_OE(TDO_OE), .SYS_OUT(SYS_OUT), .SYS_OE(SYS_OE), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN));
  bst_jtm u_bst_jtm(.CLK(CLK), .TDO(TDO), .TCK(TCK), .TMS(TMS), .TDI(TDI));
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] cap(input [7:0] o, input [7:0] e, input [7:0] p);
    cap = {e, (e & o) | (~e & p)};
  endfunction
  task cmp(input [31:0] g, input [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task print_verdict;
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task ir(input [2:0] c);
    u_bst_jtm.sh(1'b1, 3, {29'h0, c}, r);
    cmp(r[2:0], 3'h1);
  endtask
  task dr(input int n, input [31:0] v);
    u_bst_jtm.sh(1'b0, n, v, r);
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    u_bst_jtm.b(1'b0, 1'b0, r[0]);
    dr(32, 32'h0);
    cmp(r, ID);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      ir(3'(12'h9af >> (3 * i)));
      dr(9, lf);
      cmp(r[8:0], {lf[7:0], 1'b0});
    end
    lf = nx(lf);
    pv = nx(lf);
    SYS_OUT <= lf[7:0];
    SYS_OE <= lf[15:8];
    PIN_IN <= lf[23:16];
    ir(3'h1);
    dr(16, pv);
    cmp(r[15:0], cap(lf[7:0], lf[15:8], lf[23:16]));
    ir(3'h0);
    cmp({PIN_OE, PIN_OUT}, pv[15:0]);
    ir(3'h4);
    dr(9, lf);
    cmp(r[8:0], {lf[7:0], 1'b0});
    cmp({PIN_OE, PIN_OUT}, pv[15:0]);
    ir(3'h3);
    cmp(PIN_OE, 8'h00);
    cmp(PULLUP_EN, 1'b1);
    ir(3'h2);
    dr(32, lf);
    cmp(r, ID);
    TRST_N <= 1'b0;
    repeat (8) @(posedge CLK);
    TRST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    u_bst_jtm.b(1'b0, 1'b0, r[0]);
    dr(32, 32'h0);
    cmp(r, ID);
    print_verdict;
  end
endmodule
